//--- src/spi4_txcfg_params.svh
// constants for the transmit config / error status register bank
// assumes byte-wide registers at word index, byte address = 4 * index
`ifndef SPI4_TXCFG_PARAMS_SVH
`define SPI4_TXCFG_PARAMS_SVH

// ------------------------------------------------------------
// bus
// ------------------------------------------------------------
`define BUS_ADDR_W        20
`define IDX_W             18
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define IDX_SPARE_LOW     18'h30908
`define IDX_STATUS_SPARE  18'h30909
`define IDX_RX_PAR_CNT    18'h3090A
`define IDX_ST_FRM_CNT    18'h3090B
`define IDX_RX_OVR0       18'h3090C
`define IDX_RX_OVR3       18'h3090F
`define IDX_RX_ENABLES    18'h30912
`define IDX_ALIGN_ENABLE  18'h30913
`define IDX_RX_URR0       18'h30918
`define IDX_ALIGN_STATUS  18'h3091C
`define IDX_WIDTH_SEL     18'h30930
`define IDX_STARV_HI      18'h30931
`define IDX_STARV_LO      18'h30932
`define IDX_LEVEL_B_HI     18'h30933
`define IDX_LEVEL_B_LO     18'h30934
`define IDX_TRAIN_A       18'h30935
`define IDX_TRAIN_B       18'h30936
`define IDX_TRAIN_C       18'h30937
`define IDX_TRAIN_D       18'h30940
`define IDX_REPEAT_A      18'h30941
`define IDX_REPEAT_B      18'h30942
`define IDX_TX_FAULT_EN   18'h30943
`define IDX_PAR_THRESH    18'h30944
`define IDX_WATERMARKS    18'h30945
`define IDX_SPARE_HIGH    18'h30946
`define IDX_MODE          18'h30950

// ------------------------------------------------------------
// field masks and positions
// ------------------------------------------------------------
`define MASK_HI2          8'hC0
`define MASK_THRESH       8'hE0
`define BIT_LOF           7
`define BIT_MIN_BURST     0
`define CNT_MAX           8'hFF
`define RESET_BYTE        8'h00

`endif

//--- src/spi4_txcfg_pkg.sv
// types for the transmit config / error status register bank
// assumes the params header is included by users of the constants
package spi4_txcfg_pkg;

   typedef enum logic [1:0] {
      WIDTH_32  = 2'h0,
      WIDTH_64  = 2'h1,
      WIDTH_128 = 2'h2,
      WIDTH_BAD = 2'h3
   } width_sel_e;

   typedef struct packed {
      logic            awready;
      logic            wready;
      logic            aw_got;
      logic            w_got;
      logic [17:0]     aw_idx;
      logic [7:0]      wbyte;
      logic            wlane0;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            arready;
      logic            rvalid;
      logic [7:0]      rdata;
      logic [1:0]      rresp;
      logic [7:0]      width_sel;
      logic [9:0]      starv;
      logic [9:0]      level_b;
      logic [31:0]     train;
      logic            train_en;
      logic [15:0]     repeat_cnt;
      logic [7:0]      tx_fault_en;
      logic [2:0]      thresh;
      logic [7:0]      wmarks;
      logic [7:0]      spare_lo;
      logic [7:0]      spare_hi;
      logic [7:0]      rx_en;
      logic            lof_en;
      logic            min_burst;
      logic [7:0]      par_cnt;
      logic [7:0]      frm_cnt;
      logic [3:0][7:0] ovr;
      logic [7:0]      urr0;
      logic            lof_sts;
      logic            lost;
      logic [2:0]      bad_run;
      logic [2:0]      good_run;
      logic            fifo_full;
      logic [2:0]      low_mark;
      logic [3:0]      tx_ovr;
      logic [3:0]      tx_urr;
   } bank_s;

endpackage

//--- src/spi4_txcfg_regs.sv
// transmit config and error status register bank, AXI4-Lite slave
// assumes event inputs are synchronous to aclk and one cycle per event
//
// What this block does
// - level_a burst limit: 10 bits, top two in one register, low eight next
// - level_b burst limit: same 10-bit split over two registers
// - training interval is 32 bits from bytes a,b,c,d, a most significant
// - training disabled whenever the assembled interval is zero
// - training repeat count is 16 bits, byte a high, byte b low
// - fault-enable bits 0..3 gate transmit bank overrun flags
// - fault-enable bits 4..7 gate transmit bank underrun flags
// - 3-bit threshold of consecutive bad/good parity words loses/regains align
// - low watermark applies only in minimum-burst mode, else ignored
// - input fifo fill at high watermark declares full and holds off writes
// - receive parity error counter, clear on read, saturates at 255
// - status framing error counter, clear on read, saturates at 255
// - four receive overrun registers, clear on read, reset if still present
// - receive bank n overrun bits set only with overrun enable bit n
// - receive bank 0 underrun bits, gated, clear on read, re-assert
// - transmit bank 3 width select in aggregation register bits 6..7
// - width codes: 00 32-bit, 01 64-bit, 10 128-bit, 11 invalid
// - frame-loss flag asserts at threshold, gated by its own enable
`timescale 1ns/1ps
`include "spi4_txcfg_params.svh"

module spi4_txcfg_regs
(
   input  wire logic        aclk,              // 25 MHz bus clock
   input  wire logic        aresetn,           // sync reset, active low
   input  wire logic [19:0] s_axi_awaddr,      // write address
   input  wire logic [2:0]  s_axi_awprot,      // unused protection
   input  wire logic        s_axi_awvalid,     // write address valid
   output logic             s_axi_awready,     // write address ready
   input  wire logic [31:0] s_axi_wdata,       // write data
   input  wire logic [3:0]  s_axi_wstrb,       // byte strobes
   input  wire logic        s_axi_wvalid,      // write data valid
   output logic             s_axi_wready,      // write data ready
   output logic [1:0]       s_axi_bresp,       // write response
   output logic             s_axi_bvalid,      // write response valid
   input  wire logic        s_axi_bready,      // write response ready
   input  wire logic [19:0] s_axi_araddr,      // read address
   input  wire logic [2:0]  s_axi_arprot,      // unused protection
   input  wire logic        s_axi_arvalid,     // read address valid
   output logic             s_axi_arready,     // read address ready
   output logic [31:0]      s_axi_rdata,       // read data
   output logic [1:0]       s_axi_rresp,       // read response
   output logic             s_axi_rvalid,      // read data valid
   input  wire logic        s_axi_rready,      // read data ready
   input  wire logic        rx_parity_err,     // data parity error pulse
   input  wire logic        status_frame_err,  // status framing error pulse
   input  wire logic        status_word_valid, // status parity word checked
   input  wire logic        status_word_bad,   // that word failed parity
   input  wire logic [31:0] rx_overrun_cond,   // bank*8+fifo overrun level
   input  wire logic [7:0]  rx_underrun_cond,  // bank 0 underrun level
   input  wire logic [3:0]  tx_overrun_cond,   // tx bank overrun level
   input  wire logic [3:0]  tx_underrun_cond,  // tx bank underrun level
   input  wire logic [4:0]  tx_fifo_fill,      // input fifo fill level
   output logic [9:0]       level_a_burst_limit, // level_a burst limit
   output logic [9:0]       level_b_burst_limit,   // level_b burst limit
   output logic [31:0]      training_interval,    // training interval
   output logic             training_enable,      // interval non-zero
   output logic [15:0]      training_repeat_count, // repeats per interval
   output logic [1:0]       tx_bank3_width_select, // bank 3 data width
   output logic             tx_bank3_width_bad,    // code 11 selected
   output logic             min_burst_mode,        // min-burst selected
   output logic [2:0]       tx_fifo_low_mark,      // effective low mark
   output logic             tx_fifo_full,          // hold off writes
   output logic             status_frame_loss_flag, // gated loss status
   output logic             status_align_lost,     // alignment state
   output logic [3:0]       tx_bank_overrun_flag,  // gated overrun
   output logic [3:0]       tx_bank_underrun_flag  // gated underrun
);

   spi4_txcfg_pkg::bank_s s_q;
   spi4_txcfg_pkg::bank_s s_d;

   // ---------------------------------------------------------
   // read lookup: {hit, data}
   // ---------------------------------------------------------
   function automatic logic [8:0] rd_lookup
   (
      input logic [17:0]           idx,
      input spi4_txcfg_pkg::bank_s s
   );
      logic [8:0] r;
      r = {1'b1, `RESET_BYTE};
      unique case (idx)
         `IDX_SPARE_LOW:    r[7:0] = s.spare_lo;
         `IDX_STATUS_SPARE: r[7:0] = `RESET_BYTE;
         `IDX_RX_PAR_CNT:   r[7:0] = s.par_cnt;
         `IDX_ST_FRM_CNT:   r[7:0] = s.frm_cnt;
         18'h3090C:         r[7:0] = s.ovr[0];
         18'h3090D:         r[7:0] = s.ovr[1];
         18'h3090E:         r[7:0] = s.ovr[2];
         `IDX_RX_OVR3:      r[7:0] = s.ovr[3];
         `IDX_RX_ENABLES:   r[7:0] = s.rx_en;
         `IDX_ALIGN_ENABLE: r[`BIT_LOF] = s.lof_en;
         `IDX_RX_URR0:      r[7:0] = s.urr0;
         `IDX_ALIGN_STATUS: r[`BIT_LOF] = s.lof_sts;
         `IDX_WIDTH_SEL:    r[7:0] = s.width_sel;
         `IDX_STARV_HI:     r[7:6] = s.starv[9:8];
         `IDX_STARV_LO:     r[7:0] = s.starv[7:0];
         `IDX_LEVEL_B_HI:    r[7:6] = s.level_b[9:8];
         `IDX_LEVEL_B_LO:    r[7:0] = s.level_b[7:0];
         `IDX_TRAIN_A:      r[7:0] = s.train[31:24];
         `IDX_TRAIN_B:      r[7:0] = s.train[23:16];
         `IDX_TRAIN_C:      r[7:0] = s.train[15:8];
         `IDX_TRAIN_D:      r[7:0] = s.train[7:0];
         `IDX_REPEAT_A:     r[7:0] = s.repeat_cnt[15:8];
         `IDX_REPEAT_B:     r[7:0] = s.repeat_cnt[7:0];
         `IDX_TX_FAULT_EN:  r[7:0] = s.tx_fault_en;
         `IDX_PAR_THRESH:   r[7:5] = s.thresh;
         `IDX_WATERMARKS:   r[7:0] = s.wmarks;
         `IDX_SPARE_HIGH:   r[7:0] = s.spare_hi;
         `IDX_MODE:         r[`BIT_MIN_BURST] = s.min_burst;
         default:           r[8] = 1'b0;
      endcase
      return r;
   endfunction

   // saturating count, clear on read, event in the read cycle kept
   function automatic logic [7:0] cnt_next
   (
      input logic [7:0] cur,
      input logic       clr,
      input logic       evt
   );
      logic [7:0] base;
      base = clr ? `RESET_BYTE : cur;
      if (evt && base != `CNT_MAX)
         base = base + 8'h01;
      return base;
   endfunction

   // ---------------------------------------------------------
   // next state
   // ---------------------------------------------------------
   logic [8:0] rd_val;
   logic       rd_take;
   logic       wr_do;
   logic       wr_ok;
   logic [7:0] wb;
   logic [2:0] run_next;
   logic [17:0] rd_idx;

   always_comb
   begin
      s_d      = s_q;
      rd_idx   = s_axi_araddr[19:2];
      rd_val   = rd_lookup(rd_idx, s_q);
      rd_take  = s_axi_arvalid && s_q.arready;
      wb       = s_q.wbyte;
      wr_do    = 1'b0;
      wr_ok    = 1'b1;
      run_next = 3'h0;

      // write address and data, either order
      if (s_axi_awvalid && s_q.awready)
      begin
         s_d.aw_got = 1'b1;
         s_d.aw_idx = s_axi_awaddr[19:2];
      end
      if (s_axi_wvalid && s_q.wready)
      begin
         s_d.w_got  = 1'b1;
         s_d.wbyte  = s_axi_wdata[7:0];
         s_d.wlane0 = s_axi_wstrb[0];
      end
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
      begin
         wr_do      = s_q.wlane0;
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
      end
      if (s_q.bvalid && s_axi_bready)
         s_d.bvalid = 1'b0;

      if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
      begin
         unique case (s_q.aw_idx)
            `IDX_SPARE_LOW:    if (wr_do) s_d.spare_lo = wb;
            `IDX_RX_ENABLES:   if (wr_do) s_d.rx_en = wb;
            `IDX_ALIGN_ENABLE: if (wr_do) s_d.lof_en = wb[`BIT_LOF];
            `IDX_WIDTH_SEL:    if (wr_do) s_d.width_sel = wb;
            `IDX_STARV_HI:     if (wr_do) s_d.starv[9:8] = wb[7:6];
            `IDX_STARV_LO:     if (wr_do) s_d.starv[7:0] = wb;
            `IDX_LEVEL_B_HI:    if (wr_do) s_d.level_b[9:8] = wb[7:6];
            `IDX_LEVEL_B_LO:    if (wr_do) s_d.level_b[7:0] = wb;
            `IDX_TRAIN_A:      if (wr_do) s_d.train[31:24] = wb;
            `IDX_TRAIN_B:      if (wr_do) s_d.train[23:16] = wb;
            `IDX_TRAIN_C:      if (wr_do) s_d.train[15:8] = wb;
            `IDX_TRAIN_D:      if (wr_do) s_d.train[7:0] = wb;
            `IDX_REPEAT_A:     if (wr_do) s_d.repeat_cnt[15:8] = wb;
            `IDX_REPEAT_B:     if (wr_do) s_d.repeat_cnt[7:0] = wb;
            `IDX_TX_FAULT_EN:  if (wr_do) s_d.tx_fault_en = wb;
            `IDX_PAR_THRESH:   if (wr_do) s_d.thresh = wb[7:5];
            `IDX_WATERMARKS:   if (wr_do) s_d.wmarks = wb;
            `IDX_SPARE_HIGH:   if (wr_do) s_d.spare_hi = wb;
            `IDX_MODE:         if (wr_do) s_d.min_burst = wb[`BIT_MIN_BURST];
            // read-only registers ignore writes
            `IDX_STATUS_SPARE, `IDX_RX_PAR_CNT, `IDX_ST_FRM_CNT,
            18'h3090C, 18'h3090D, 18'h3090E, `IDX_RX_OVR3,
            `IDX_RX_URR0, `IDX_ALIGN_STATUS: wr_ok = 1'b1;
            default:           wr_ok = 1'b0;
         endcase
         s_d.bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end

      // read channel; data captured before the clear applies
      if (rd_take)
      begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = rd_val[7:0];
         s_d.rresp  = rd_val[8] ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_q.rvalid && s_axi_rready)
         s_d.rvalid = 1'b0;

      // error counters
      s_d.par_cnt = cnt_next(s_q.par_cnt,
                       rd_take && rd_idx == `IDX_RX_PAR_CNT,
                       rx_parity_err);
      s_d.frm_cnt = cnt_next(s_q.frm_cnt,
                       rd_take && rd_idx == `IDX_ST_FRM_CNT,
                       status_frame_err);

      // receive overrun / underrun flags
      for (int b = 0; b < 4; b++)
      begin
         if (rd_take && rd_idx == `IDX_RX_OVR0 + 18'(b))
            s_d.ovr[b] = `RESET_BYTE;
         s_d.ovr[b] = s_d.ovr[b] |
            (rx_overrun_cond[b*8 +: 8] & {8{s_q.rx_en[b]}});
      end
      if (rd_take && rd_idx == `IDX_RX_URR0)
         s_d.urr0 = `RESET_BYTE;
      s_d.urr0 = s_d.urr0 |
         (rx_underrun_cond & {8{s_q.rx_en[4]}});

      // status alignment tracking
      if (status_word_valid)
      begin
         if (status_word_bad)
         begin
            run_next     = (s_q.bad_run == 3'h7) ? 3'h7 :
                           s_q.bad_run + 3'h1;
            s_d.bad_run  = run_next;
            s_d.good_run = 3'h0;
            if (run_next >= s_q.thresh)
               s_d.lost = 1'b1;
         end
         else
         begin
            run_next     = (s_q.good_run == 3'h7) ? 3'h7 :
                           s_q.good_run + 3'h1;
            s_d.good_run = run_next;
            s_d.bad_run  = 3'h0;
            if (run_next >= s_q.thresh)
               s_d.lost = 1'b0;
         end
      end
      if (rd_take && rd_idx == `IDX_ALIGN_STATUS)
         s_d.lof_sts = 1'b0;
      if (s_d.lost && s_q.lof_en)
         s_d.lof_sts = 1'b1;

      // derived outputs
      s_d.train_en  = (s_d.train != 32'h0);
      s_d.low_mark  = s_d.min_burst ? s_d.wmarks[2:0] : 3'h0;
      s_d.fifo_full = (tx_fifo_fill >= s_d.wmarks[7:3]);
      s_d.tx_ovr    = tx_overrun_cond & s_d.tx_fault_en[3:0];
      s_d.tx_urr    = tx_underrun_cond & s_d.tx_fault_en[7:4];

      // ready flags follow the held state
      s_d.awready = !s_d.aw_got && !s_d.bvalid;
      s_d.wready  = !s_d.w_got && !s_d.bvalid;
      s_d.arready = !s_d.rvalid;
   end

   // ---------------------------------------------------------
   // state register
   // ---------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // ---------------------------------------------------------
   // outputs
   // ---------------------------------------------------------
   assign s_axi_awready          = s_q.awready;
   assign s_axi_wready           = s_q.wready;
   assign s_axi_bvalid           = s_q.bvalid;
   assign s_axi_bresp            = s_q.bresp;
   assign s_axi_arready          = s_q.arready;
   assign s_axi_rvalid           = s_q.rvalid;
   assign s_axi_rdata            = {24'h000000, s_q.rdata};
   assign s_axi_rresp            = s_q.rresp;
   assign level_a_burst_limit   = s_q.starv;
   assign level_b_burst_limit     = s_q.level_b;
   assign training_interval      = s_q.train;
   assign training_enable        = s_q.train_en;
   assign training_repeat_count  = s_q.repeat_cnt;
   assign tx_bank3_width_select  = s_q.width_sel[7:6];
   assign tx_bank3_width_bad     = (s_q.width_sel[7:6] ==
                                    spi4_txcfg_pkg::WIDTH_BAD);
   assign min_burst_mode         = s_q.min_burst;
   assign tx_fifo_low_mark       = s_q.low_mark;
   assign tx_fifo_full           = s_q.fifo_full;
   assign status_frame_loss_flag = s_q.lof_sts;
   assign status_align_lost      = s_q.lost;
   assign tx_bank_overrun_flag   = s_q.tx_ovr;
   assign tx_bank_underrun_flag  = s_q.tx_urr;

endmodule

//--- verif/spi4_txcfg_monitor.sv
// port assertions for the transmit config / error status bank
// assumes bind onto spi4_txcfg_regs, one clock, sync reset
`timescale 1ns/1ps

module spi4_txcfg_monitor
(
   input wire logic        aclk,                   // clock
   input wire logic        aresetn,                // reset
   input wire logic        s_axi_awvalid,          // aw valid
   input wire logic        s_axi_awready,          // aw ready
   input wire logic        s_axi_wvalid,           // w valid
   input wire logic        s_axi_wready,           // w ready
   input wire logic        s_axi_bvalid,           // b valid
   input wire logic        s_axi_arvalid,          // ar valid
   input wire logic        s_axi_arready,          // ar ready
   input wire logic        s_axi_rvalid,           // r valid
   input wire logic [31:0] s_axi_rdata,            // r data
   input wire logic        status_word_valid,      // word checked
   input wire logic        status_word_bad,        // word failed
   input wire logic [3:0]  tx_overrun_cond,        // overrun level
   input wire logic [3:0]  tx_underrun_cond,       // underrun level
   input wire logic [31:0] training_interval,      // interval
   input wire logic        training_enable,        // interval non-zero
   input wire logic [1:0]  tx_bank3_width_select,  // width code
   input wire logic        tx_bank3_width_bad,     // invalid code
   input wire logic        min_burst_mode,         // min burst
   input wire logic [2:0]  tx_fifo_low_mark,       // low mark
   input wire logic        status_frame_loss_flag, // loss flag
   input wire logic        status_align_lost,      // align state
   input wire logic [3:0]  tx_bank_overrun_flag,   // gated overrun
   input wire logic [3:0]  tx_bank_underrun_flag   // gated underrun
);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ------------------------------------------------------------
   // configuration outputs
   // ------------------------------------------------------------
   property p_train_en; training_enable == (training_interval != 32'h0); endproperty
   a_train_en: assert property (p_train_en) else $error("train enable off");
   property p_width_bad; tx_bank3_width_bad == (tx_bank3_width_select == 2'h3); endproperty
   a_width_bad: assert property (p_width_bad) else $error("width bad off");
   property p_low_mark; !min_burst_mode |-> tx_fifo_low_mark == 3'h0; endproperty
   a_low_mark: assert property (p_low_mark) else $error("low mark used");
   property p_ovr_gate; (tx_bank_overrun_flag & ~$past(tx_overrun_cond)) == 4'h0; endproperty
   a_ovr_gate: assert property (p_ovr_gate) else $error("overrun no cause");
   property p_urr_gate; (tx_bank_underrun_flag & ~$past(tx_underrun_cond)) == 4'h0; endproperty
   a_urr_gate: assert property (p_urr_gate) else $error("underrun no cause");

   // ------------------------------------------------------------
   // alignment and bus
   // ------------------------------------------------------------
   property p_lost_set; $rose(status_align_lost) |-> $past(status_word_valid && status_word_bad); endproperty
   a_lost_set: assert property (p_lost_set) else $error("loss no bad word");
   property p_lost_clr; $fell(status_align_lost) |-> $past(status_word_valid && !status_word_bad); endproperty
   a_lost_clr: assert property (p_lost_clr) else $error("regain no good word");
   property p_lof_set; $rose(status_frame_loss_flag) |-> status_align_lost; endproperty
   a_lof_set: assert property (p_lof_set) else $error("loss flag no cause");
   property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
   property p_rd_hi; s_axi_rdata[31:8] == 24'h0; endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("read upper bits set");

endmodule

bind spi4_txcfg_regs spi4_txcfg_monitor mon_u (.*);

//--- verif/testbench.sv
// self-checking bench for the transmit config / error status bank
// assumes byte address = 4 * index and the design's bus timing
`timescale 1ns/1ps
`include "spi4_txcfg_params.svh"

module testbench;
   logic        aclk, aresetn, awv, wv, brdy, arv, rrdy, awr, wr_r, bv, arr, rv;
   logic        perr, ferr, swv, swb, ten, w3bad, minb, full, lof, lost;
   logic [19:0] awa, ara;
   logic [31:0] wd, rdat, rxo, train;
   logic [1:0]  br, rr, w3sel, rsp;
   logic [7:0]  rxu, d;
   logic [3:0]  txo, txu, ovf, urf;
   logic [4:0]  fill;
   logic [9:0]  starv, hung;
   logic [15:0] rep;
   logic [2:0]  lowm;
   int          miscompares, cmp_count;
   typedef struct { logic [17:0] i; logic [7:0] v; } row_t;
   row_t rows [16] = '{'{`IDX_SPARE_LOW, 8'hA5}, '{`IDX_STARV_HI, 8'hC0},
      '{`IDX_STARV_LO, 8'h5A}, '{`IDX_LEVEL_B_HI, 8'h80}, '{`IDX_LEVEL_B_LO, 8'hA5},
      '{`IDX_TRAIN_A, 8'h12}, '{`IDX_TRAIN_B, 8'h34}, '{`IDX_TRAIN_C, 8'h56},
      '{`IDX_TRAIN_D, 8'h78}, '{`IDX_REPEAT_A, 8'hBE}, '{`IDX_REPEAT_B, 8'hEF},
      '{`IDX_TX_FAULT_EN, 8'h5A}, '{`IDX_PAR_THRESH, 8'h60},
      '{`IDX_WATERMARKS, 8'h43}, '{`IDX_SPARE_HIGH, 8'h3C}, '{`IDX_WIDTH_SEL, 8'h80}};

   spi4_txcfg_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
      .rx_parity_err(perr), .status_frame_err(ferr), .status_word_valid(swv),
      .status_word_bad(swb), .rx_overrun_cond(rxo), .rx_underrun_cond(rxu),
      .tx_overrun_cond(txo), .tx_underrun_cond(txu), .tx_fifo_fill(fill),
      .level_a_burst_limit(starv), .level_b_burst_limit(hung),
      .training_interval(train), .training_enable(ten),
      .training_repeat_count(rep), .tx_bank3_width_select(w3sel),
      .tx_bank3_width_bad(w3bad), .min_burst_mode(minb), .tx_fifo_low_mark(lowm),
      .tx_fifo_full(full), .status_frame_loss_flag(lof),
      .status_align_lost(lost), .tx_bank_overrun_flag(ovf),
      .tx_bank_underrun_flag(urf));

   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      if (miscompares == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic wr(input logic [17:0] i, input logic [7:0] v, output logic [1:0] r);
      int n;
      awa <= {i, 2'h0};
      wd <= {24'h0, v};
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
         if (bv) break;
      end
      r = br;
      brdy <= 1'b0;
      if (n == 100)
      begin
         miscompares++;
         complete_run();
      end
      @(posedge aclk);
   endtask

   task automatic rd(input logic [17:0] i, output logic [7:0] v, output logic [1:0] r);
      int n;
      ara <= {i, 2'h0};
      arv <= 1'b1;
      rrdy <= 1'b1;
      for (n = 0; n < 100; n++)
      begin
         @(posedge aclk);
         if (arr) arv <= 1'b0;
         if (rv) break;
      end
      v = rdat[7:0];
      r = rr;
      rrdy <= 1'b0;
      if (n == 100)
      begin
         miscompares++;
         complete_run();
      end
      @(posedge aclk);
   endtask

   // read and compare against the expected byte, answer OKAY
   task automatic rc(input logic [17:0] i, input logic [7:0] e);
      logic [7:0] v;
      logic [1:0] r;
      rd(i, v, r);
      chk(v, e);
      chk(r, `RESP_OKAY);
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // status words of one kind, then idle
   task automatic words(input int n, input logic b);
      swv <= 1'b1;
      swb <= b;
      ticks(n);
      swv <= 1'b0;
      swb <= 1'b0;
      ticks(2);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      {aresetn, awv, wv, brdy, arv, rrdy, perr, ferr, swv, swb} = '0;
      {awa, ara, wd, rxo, rxu, txo, txu, fill} = '0;
      ticks(2);
      aresetn <= 1'b1;
      ticks(2);
      chk(ten, 1'b0);
      foreach (rows[k])
      begin
         rc(rows[k].i, `RESET_BYTE);
         wr(rows[k].i, rows[k].v, rsp);
         chk(rsp, `RESP_OKAY);
         rc(rows[k].i, rows[k].v);
      end
      chk(starv, 10'h35A);
      chk(hung, 10'h2A5);
      chk(train, 32'h12345678);
      chk(ten, 1'b1);
      chk(rep, 16'hBEEF);
      chk(w3sel, 2'h2);
      for (int k = 0; k < 4; k++)
      begin
         wr(`IDX_WIDTH_SEL, {k[1:0], 6'h0}, rsp);
         chk(w3sel, k[1:0]);
         chk(w3bad, k == 3);
      end
      for (int k = 5; k < 9; k++) wr(rows[k].i, 8'h00, rsp);
      chk(ten, 1'b0);
      wr(18'h30900, 8'h11, rsp);
      chk(rsp, `RESP_SLVERR);
      rd(18'h30900, d, rsp);
      chk(rsp, `RESP_SLVERR);
      // low mark 3 suits 8-line bursts: 8 / 4 + 1, high mark 8
      chk(lowm, 3'h0);
      wr(`IDX_MODE, 8'h01, rsp);
      chk(minb, 1'b1);
      chk(lowm, 3'h3);
      fill <= 5'd7;
      txo <= 4'hF;
      txu <= 4'hF;
      ticks(3);
      chk(full, 1'b0);
      chk(ovf, 4'hA);
      chk(urf, 4'h5);
      fill <= 5'd8;
      ticks(3);
      chk(full, 1'b1);
      wr(`IDX_RX_ENABLES, 8'h12, rsp);
      rxo <= 32'h0000_0401;
      rxu <= 8'h81;
      ticks(2);
      rc(`IDX_RX_OVR0, 8'h00);
      rc(`IDX_RX_OVR0 + 18'h1, 8'h04);
      rc(`IDX_RX_OVR0 + 18'h1, 8'h04);
      rc(`IDX_RX_URR0, 8'h81);
      rxo <= '0;
      rxu <= '0;
      ticks(2);
      rc(`IDX_RX_OVR0 + 18'h1, 8'h04);
      rc(`IDX_RX_OVR0 + 18'h1, 8'h00);
      rc(`IDX_RX_URR0, 8'h81);
      rc(`IDX_RX_URR0, 8'h00);
      for (int n = 3; n < 264; n = n + 257)
      begin
         perr <= 1'b1;
         ferr <= 1'b1;
         ticks(n);
         perr <= 1'b0;
         ferr <= 1'b0;
         ticks(1);
         rc(`IDX_RX_PAR_CNT, (n > 255) ? 8'hFF : n[7:0]);
         rc(`IDX_ST_FRM_CNT, (n > 255) ? 8'hFF : n[7:0]);
         rc(`IDX_RX_PAR_CNT, 8'h00);
         rc(`IDX_ST_FRM_CNT, 8'h00);
      end
      wr(`IDX_ALIGN_ENABLE, 8'h80, rsp);
      words(2, 1'b1);
      chk(lost, 1'b0);
      words(3, 1'b1);
      chk(lost, 1'b1);
      chk(lof, 1'b1);
      rc(`IDX_ALIGN_STATUS, 8'h80);
      words(3, 1'b0);
      chk(lost, 1'b0);
      complete_run();
   end
endmodule
